/* File: core/fpi_regs.svh */
// Register map and timing constants of the frequency-pull I2C controller
`ifndef FPI_REGS_SVH
`define FPI_REGS_SVH

`define FPI_REG_LOWER_WORD 8'h00
`define FPI_REG_UPPER_WORD 8'h01
`define FPI_REG_PULL_RANGE 8'h02
`define FPI_UPPER_WORD_MSB 9
`define FPI_OUT_ENABLE_BIT 10
`define FPI_PULL_RANGE_MSB 3
`define FPI_PULL_RANGE_MASK 16'h000f
`define FPI_UPPER_WORD_RESET 16'h0000
`define FPI_LOWER_WORD_RESET 16'h0000
`define FPI_RESET_REG_PTR 8'h00

`define FPI_CLK_NS 40
`define FPI_CLK_MHZ 25
`define FPI_SCL_MIN_PERIOD_NS 1000
`define FPI_SCL_QTR_CYC ((`FPI_SCL_MIN_PERIOD_NS + 4 * `FPI_CLK_NS - 1) / (4 * `FPI_CLK_NS))
`define FPI_PULL_LAT_US 140
`define FPI_SETTLE_US 20
`define FPI_PULL_WAIT_CYC ((`FPI_PULL_LAT_US + `FPI_SETTLE_US) * `FPI_CLK_MHZ)
`define FPI_ACK_BIT 4'd8

`endif

/* File: core/fpi_pkg.sv */
// Types shared by the frequency-pull I2C controller
package fpi_pkg;
    typedef enum logic [1:0] {
        FPI_OP_WRITE = 2'b00,
        FPI_OP_WORD  = 2'b01,
        FPI_OP_READ  = 2'b10
    } fpi_op_t;

    typedef enum logic [1:0] {
        FPI_SK_START = 2'b00,
        FPI_SK_TX    = 2'b01,
        FPI_SK_RX    = 2'b10,
        FPI_SK_STOP  = 2'b11
    } fpi_kind_t;

    typedef enum logic [1:0] {
        FPI_ST_IDLE  = 2'b00,
        FPI_ST_START = 2'b01,
        FPI_ST_BIT   = 2'b10,
        FPI_ST_STOP  = 2'b11
    } fpi_state_t;

    typedef struct packed {
        fpi_op_t op;
        logic [6:0] dev_addr;
        logic [7:0] reg_addr;
        logic [31:0] data;
    } fpi_cmd_t;

    typedef struct packed {
        logic nack;
        logic [15:0] rdata;
    } fpi_rsp_t;

    typedef struct packed {
        fpi_kind_t kind;
        logic [7:0] data;
    } fpi_step_t;
endpackage : fpi_pkg

/* File: core/fpi_host.sv */
// I2C controller that writes and reads the frequency-pull registers of the oscillator
`timescale 1ns/1ps
`default_nettype none
`include "fpi_regs.svh"

// Behaviour
// - SDA changes only while SCL low, steady while SCL high.
// - Controller frames each transfer with START and STOP.
// - Bytes are eight bits, MSB first, any count per transfer.
// - Transmitter releases SDA on ninth pulse; low means acknowledge.
// - Controller acknowledges the last read byte so device releases SDA.
// - First byte is 7-bit address then direction, 1 read.
// - Controller uses auto advancing only for consecutive writes.
// - Register values move as two bytes, high byte first.
// - Controller writes the register address before reading.
// - Control word goes as four bytes from the lower word register.
// - Lower word is written before the upper word.
module fpi_host
    import fpi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire fpi_cmd_t cmd,
    input wire logic cmd_valid,
    output logic cmd_ready,
    output fpi_rsp_t rsp,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic pull_busy,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n
);
    localparam int QTR = `FPI_SCL_QTR_CYC;
    localparam logic [3:0] QTR_LAST = 4'(QTR - 1);
    localparam logic [11:0] PULL_WAIT = 12'(`FPI_PULL_WAIT_CYC);

    // Step list of each command; a NACK cuts it short to STOP
    function automatic fpi_step_t step_of(input fpi_cmd_t c, input logic [2:0] i);
        fpi_step_t s;
        s.kind = FPI_SK_STOP;
        s.data = 8'h00;
        if (i == 3'd0) begin
            s.kind = FPI_SK_START;
        end else if (i == 3'd1) begin
            s = '{FPI_SK_TX, {c.dev_addr, 1'b0}};
        end else if (c.op == FPI_OP_WORD) begin
            unique case (i)
                3'd2: s = '{FPI_SK_TX, `FPI_REG_LOWER_WORD};
                3'd3: s = '{FPI_SK_TX, c.data[15:8]};
                3'd4: s = '{FPI_SK_TX, c.data[7:0]};
                3'd5: s = '{FPI_SK_TX, c.data[31:24]};
                3'd6: s = '{FPI_SK_TX, c.data[23:16]};
                default: s.kind = FPI_SK_STOP;
            endcase
        end else if (c.op == FPI_OP_READ) begin
            unique case (i)
                3'd2: s = '{FPI_SK_TX, c.reg_addr};
                3'd3: s.kind = FPI_SK_START;
                3'd4: s = '{FPI_SK_TX, {c.dev_addr, 1'b1}};
                3'd5: s.kind = FPI_SK_RX;
                3'd6: s.kind = FPI_SK_RX;
                default: s.kind = FPI_SK_STOP;
            endcase
        end else begin
            unique case (i)
                3'd2: s = '{FPI_SK_TX, c.reg_addr};
                3'd3: s = '{FPI_SK_TX, c.data[15:8]};
                3'd4: s = '{FPI_SK_TX, c.data[7:0]};
                default: s.kind = FPI_SK_STOP;
            endcase
        end
        return s;
    endfunction : step_of

    function automatic fpi_state_t state_of(input fpi_kind_t k);
        fpi_state_t st;
        unique case (k)
            FPI_SK_START: st = FPI_ST_START;
            FPI_SK_STOP: st = FPI_ST_STOP;
            default: st = FPI_ST_BIT;
        endcase
        return st;
    endfunction : state_of

    logic scl_meta_ff, scl_sync_ff, sda_meta_ff, sda_sync_ff;
    fpi_state_t state_ff;
    fpi_cmd_t cmd_ff;
    fpi_kind_t kind_ff;
    fpi_step_t nxt_step;
    logic [3:0] qcnt_ff;
    logic [1:0] q_ff;
    logic [2:0] idx_ff;
    logic [3:0] bit_ff;
    logic [7:0] shift_ff;
    logic [15:0] rdata_ff;
    logic nack_ff, cmd_ready_ff, scl_oe_n_ff, sda_oe_n_ff;
    logic head_v_ff, spare_v_ff;
    fpi_rsp_t head_ff, spare_ff;
    logic [11:0] pull_cnt_ff;
    logic pull_busy_ff;
    logic take, tick, stretch, sample, step_end, push, pop;
    logic pull_scl, pull_sda;

    // Pins pass two flops before any logic sees them
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_meta_ff <= 1'b1;
            scl_sync_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            sda_sync_ff <= 1'b1;
        end else begin
            scl_meta_ff <= scl_in;
            scl_sync_ff <= scl_meta_ff;
            sda_meta_ff <= sda_in;
            sda_sync_ff <= sda_meta_ff;
        end
    end

    assign take = cmd_valid && cmd_ready_ff;
    // Hold the quarter timer in the second high quarter while the target holds SCL low
    assign stretch = state_ff == FPI_ST_BIT && q_ff == 2'd2 && !scl_sync_ff;
    assign tick = qcnt_ff == QTR_LAST && !stretch;
    assign sample = tick && state_ff == FPI_ST_BIT && q_ff == 2'd2;
    assign step_end = tick && q_ff == 2'd3
                      && (state_ff != FPI_ST_BIT || bit_ff == `FPI_ACK_BIT);
    assign push = step_end && state_ff == FPI_ST_STOP;
    assign pop = head_v_ff && rsp_ready;
    assign nxt_step = step_of(cmd_ff, idx_ff + 3'd1);

    // Quarter-bit timer; SCL is a divided copy of clk_sys
    always_ff @(posedge clk_sys) begin
        if (reset || state_ff == FPI_ST_IDLE) begin
            qcnt_ff <= 4'h0;
            q_ff <= 2'd0;
        end else if (tick) begin
            qcnt_ff <= 4'h0;
            q_ff <= q_ff + 2'd1;
        end else if (!stretch) begin
            qcnt_ff <= qcnt_ff + 4'h1;
        end
    end

    // Command sequencer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= FPI_ST_IDLE;
            cmd_ff <= '0;
            idx_ff <= 3'd0;
            kind_ff <= FPI_SK_START;
        end else if (state_ff == FPI_ST_IDLE) begin
            if (take) begin
                cmd_ff <= cmd;
                idx_ff <= 3'd0;
                kind_ff <= FPI_SK_START;
                state_ff <= FPI_ST_START;
            end
        end else if (step_end) begin
            if (state_ff == FPI_ST_STOP) begin
                state_ff <= FPI_ST_IDLE;
            end else if (nack_ff) begin
                state_ff <= FPI_ST_STOP;
                kind_ff <= FPI_SK_STOP;
            end else begin
                idx_ff <= idx_ff + 3'd1;
                kind_ff <= nxt_step.kind;
                state_ff <= state_of(nxt_step.kind);
            end
        end
    end

    // Byte engine: eight data bits MSB first, then the ninth acknowledge bit
    always_ff @(posedge clk_sys) begin
        if (reset || state_ff == FPI_ST_IDLE) begin
            bit_ff <= 4'd0;
            shift_ff <= 8'h00;
        end else if (step_end) begin
            bit_ff <= 4'd0;
            shift_ff <= nxt_step.data;
        end else if (state_ff == FPI_ST_START && idx_ff == 3'd0) begin
            shift_ff <= step_of(cmd_ff, 3'd1).data;
        end else if (tick && q_ff == 2'd3 && state_ff == FPI_ST_BIT) begin
            bit_ff <= bit_ff + 4'd1;
            shift_ff <= {shift_ff[6:0], 1'b0};
        end
    end

    // Acknowledge check and read data capture
    always_ff @(posedge clk_sys) begin
        if (reset || take) begin
            nack_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else if (sample) begin
            if (kind_ff == FPI_SK_TX && bit_ff == `FPI_ACK_BIT) begin
                nack_ff <= sda_sync_ff;
            end else if (kind_ff == FPI_SK_RX && bit_ff != `FPI_ACK_BIT) begin
                rdata_ff <= {rdata_ff[14:0], sda_sync_ff};
            end
        end
    end

    // Open-drain drive: only pull low, never drive high
    always_comb begin
        pull_scl = 1'b0;
        pull_sda = 1'b0;
        unique case (state_ff)
            FPI_ST_IDLE: begin
                pull_scl = 1'b0;
            end
            FPI_ST_START: begin
                // Keep SCL low in quarter 0 so a repeated START cannot look like STOP
                pull_scl = q_ff == 2'd0 ? !scl_oe_n_ff : q_ff == 2'd3;
                pull_sda = q_ff[1];
            end
            FPI_ST_BIT: begin
                pull_scl = q_ff == 2'd0 || q_ff == 2'd3;
                if (kind_ff == FPI_SK_TX) begin
                    pull_sda = bit_ff != `FPI_ACK_BIT && !shift_ff[7];
                end else begin
                    pull_sda = bit_ff == `FPI_ACK_BIT;
                end
            end
            FPI_ST_STOP: begin
                pull_scl = q_ff == 2'd0;
                pull_sda = !q_ff[1];
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_oe_n_ff <= 1'b1;
            sda_oe_n_ff <= 1'b1;
        end else begin
            scl_oe_n_ff <= !pull_scl;
            sda_oe_n_ff <= !pull_sda;
        end
    end

    // Two-entry response buffer; a full buffer holds off new commands
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            head_v_ff <= 1'b0;
            spare_v_ff <= 1'b0;
            head_ff <= '0;
            spare_ff <= '0;
        end else if (pop && spare_v_ff) begin
            head_ff <= spare_ff;
            spare_v_ff <= push;
            if (push) begin
                spare_ff <= '{nack_ff, rdata_ff};
            end
        end else if (pop) begin
            head_v_ff <= push;
            if (push) begin
                head_ff <= '{nack_ff, rdata_ff};
            end
        end else if (push && !head_v_ff) begin
            head_v_ff <= 1'b1;
            head_ff <= '{nack_ff, rdata_ff};
        end else if (push) begin
            spare_v_ff <= 1'b1;
            spare_ff <= '{nack_ff, rdata_ff};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cmd_ready_ff <= 1'b0;
        end else begin
            cmd_ready_ff <= state_ff == FPI_ST_IDLE && !take && !push && !spare_v_ff;
        end
    end

    // Worst-case pull latency plus settling after an upper word write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pull_cnt_ff <= 12'h000;
            pull_busy_ff <= 1'b0;
        end else if (push && cmd_ff.op != FPI_OP_READ && !nack_ff
                     && (cmd_ff.op == FPI_OP_WORD || cmd_ff.reg_addr == `FPI_REG_UPPER_WORD)) begin
            pull_cnt_ff <= PULL_WAIT;
            pull_busy_ff <= 1'b1;
        end else if (pull_cnt_ff != 12'h000) begin
            pull_cnt_ff <= pull_cnt_ff - 12'h001;
            pull_busy_ff <= pull_cnt_ff != 12'h001;
        end
    end

    assign cmd_ready = cmd_ready_ff;
    assign rsp = head_ff;
    assign rsp_valid = head_v_ff;
    assign pull_busy = pull_busy_ff;
    assign scl_oe_n = scl_oe_n_ff;
    assign sda_oe_n = sda_oe_n_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sda_steady_high_a: assert property (
        state_ff == FPI_ST_BIT && scl_oe_n_ff && $past(scl_oe_n_ff) |-> $stable(sda_oe_n_ff))
        else $error("SDA moved while SCL high");
    start_shape_a: assert property (
        state_ff == FPI_ST_START && q_ff == 2'd2 && qcnt_ff == 4'd1 |-> scl_oe_n_ff && !sda_oe_n_ff)
        else $error("START not SDA low with SCL high");
    stop_shape_a: assert property (
        push |=> scl_oe_n_ff && sda_oe_n_ff && state_ff == FPI_ST_IDLE)
        else $error("STOP did not leave bus released");
    byte_length_a: assert property (
        state_ff == FPI_ST_BIT |-> bit_ff <= `FPI_ACK_BIT)
        else $error("Byte longer than nine bits");
    tx_ack_release_a: assert property (
        state_ff == FPI_ST_BIT && kind_ff == FPI_SK_TX && bit_ff == `FPI_ACK_BIT
        && $past(state_ff == FPI_ST_BIT && bit_ff == `FPI_ACK_BIT) |-> sda_oe_n_ff)
        else $error("SDA not released on acknowledge");
    rx_ack_drive_a: assert property (
        state_ff == FPI_ST_BIT && kind_ff == FPI_SK_RX && bit_ff == `FPI_ACK_BIT
        && $past(state_ff == FPI_ST_BIT && bit_ff == `FPI_ACK_BIT) |-> !sda_oe_n_ff)
        else $error("Read byte not acknowledged");
    read_dir_bit_a: assert property (
        state_ff == FPI_ST_BIT && kind_ff == FPI_SK_TX && idx_ff == 3'd4 && bit_ff == 4'd7
        && cmd_ff.op == FPI_OP_READ && q_ff == 2'd1 |-> sda_oe_n_ff)
        else $error("Read direction bit not one");
    word_reg_first_a: assert property (
        cmd_ff.op == FPI_OP_WORD && idx_ff == 3'd1 && step_end && !nack_ff
        |=> shift_ff == `FPI_REG_LOWER_WORD)
        else $error("Control word not sent from lower register");
    pull_wait_a: assert property (
        $rose(pull_busy_ff) |-> pull_busy_ff [*8])
        else $error("Pull wait ended early");
    nack_stop_a: assert property (
        step_end && nack_ff && state_ff == FPI_ST_BIT |=> state_ff == FPI_ST_STOP)
        else $error("NACK did not lead to STOP");

    write_seen_c: cover property (push && cmd_ff.op == FPI_OP_WRITE && !nack_ff);
    word_seen_c: cover property (push && cmd_ff.op == FPI_OP_WORD);
    read_seen_c: cover property (push && cmd_ff.op == FPI_OP_READ && !nack_ff);
    nack_seen_c: cover property (push && nack_ff);
    buffer_full_c: cover property (head_v_ff && spare_v_ff);
endmodule : fpi_host
`default_nettype wire

/* File: dv/fpi_dev_model.sv */
// Behavioural I2C target model of the pulled oscillator and its registers
`timescale 1ns/1ps
`default_nettype none
module fpi_dev_model #(
    parameter logic [6:0] DEV_ADDR = 7'h35, // Arbitrary target address
    parameter logic [3:0] RANGE_DEFAULT = 4'h9 // Arbitrary factory setting
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull,
    output logic [7:0] reg_ptr,
    output logic [7:0] upper_loads
);
    logic [15:0] lower_ff = 16'h0000;
    logic [10:0] upper_ff = 11'h000;
    logic [3:0] range_ff = RANGE_DEFAULT;
    logic [15:0] rv;
    logic [7:0] sh, obyte, hold;
    logic [2:0] phase = 3'h0;
    logic [3:0] bitcnt = 4'h0;
    logic seen_hi = 1'b0, hi = 1'b1, first = 1'b0, ack_ok = 1'b0, commit = 1'b0;

    // Only SDA is ever pulled; the clock stays the controller's
    initial begin
        sda_pull = 1'b0;
        reg_ptr = 8'h00;
        upper_loads = 8'h00;
    end

    task load_byte;
        case (reg_ptr)
            8'h00: rv = lower_ff;
            8'h01: rv = {5'h00, upper_ff};
            8'h02: rv = {12'h000, range_ff};
            default: rv = 16'h0000;
        endcase
        obyte = hi ? rv[15:8] : rv[7:0];
        sda_pull = ~obyte[7];
    endtask : load_byte

    task take_byte;
        case (phase)
            3'h1: begin
                first = 1'b1;
                hi = 1'b1;
                phase = (sh[7:1] == DEV_ADDR) ? (sh[0] ? 3'h4 : 3'h2) : 3'h5;
                sda_pull = (sh[7:1] == DEV_ADDR);
            end
            3'h2: begin
                reg_ptr = sh;
                phase = 3'h3;
                sda_pull = 1'b1;
            end
            default: begin
                if (hi) hold = sh;
                else commit = 1'b1;
                hi = ~hi;
                sda_pull = 1'b1;
            end
        endcase
    endtask : take_byte

    always @(negedge sda) begin
        if (scl === 1'b1) begin
            phase = 3'h1;
            bitcnt = 4'h0;
            seen_hi = 1'b0;
            sda_pull = 1'b0;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            phase = 3'h0;
            sda_pull = 1'b0;
        end
    end
    always @(posedge scl) begin
        seen_hi = 1'b1;
        if (bitcnt < 4'h8) sh = {sh[6:0], sda};
        else ack_ok = (sda === 1'b0);
    end
    // The falling edge after START is skipped: no high phase was seen
    always @(negedge scl) begin
        if (seen_hi && phase != 3'h0 && phase != 3'h5) begin
            seen_hi = 1'b0;
            if (bitcnt == 4'h7) begin
                bitcnt = 4'h8;
                sda_pull = 1'b0;
                if (phase != 3'h4) take_byte();
            end else if (bitcnt == 4'h8) begin
                bitcnt = 4'h0;
                sda_pull = 1'b0;
                if (commit) begin
                    commit = 1'b0;
                    if (reg_ptr == 8'h00) lower_ff = {hold, sh};
                    if (reg_ptr == 8'h01) begin
                        upper_ff = {hold[2:0], sh};
                        upper_loads = upper_loads + 8'h01;
                    end
                    if (reg_ptr == 8'h02) range_ff = sh[3:0];
                    reg_ptr = reg_ptr + 8'h01;
                end
                if (phase == 3'h4) begin
                    if (first) first = 1'b0;
                    else if (hi) hi = 1'b0;
                    else begin
                        hi = 1'b1;
                        reg_ptr = reg_ptr + 8'h01;
                        if (ack_ok) phase = 3'h5;
                    end
                    if (phase == 3'h4) load_byte();
                end
            end else begin
                bitcnt = bitcnt + 4'h1;
                if (phase == 3'h4) sda_pull = ~obyte[4'h7 - bitcnt[2:0]];
            end
        end
    end
endmodule : fpi_dev_model
`default_nettype wire

/* File: dv/fpi_host_tb.sv */
// Self-checking bench of the frequency-pull I2C controller against the target model
`timescale 1ns/1ps
`default_nettype none
`include "fpi_regs.svh"
module fpi_host_tb
    import fpi_pkg::*;
;
    localparam logic [6:0] DA = 7'h35;
    localparam logic [3:0] RDEF = 4'h9;
    localparam int WAIT_CYC = `FPI_PULL_WAIT_CYC;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    fpi_cmd_t cmd = '0;
    logic cmd_valid = 1'b0;
    logic rsp_ready = 1'b0;
    logic cmd_ready, rsp_valid, pull_busy, scl_out, scl_oe_n, sda_out, sda_oe_n, dev_pull;
    logic scl, sda;
    logic [7:0] ptr, loads;
    fpi_rsp_t rsp, r;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    int n;

    always #20 clk_sys = ~clk_sys;
    // Released lines float high through the pull-ups
    assign scl = scl_oe_n ? 1'b1 : scl_out;
    assign sda = (sda_oe_n ? 1'b1 : sda_out) & ~dev_pull;

    fpi_host i_fpi_host (.clk_sys(clk_sys), .reset(reset), .cmd(cmd), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .rsp(rsp), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .pull_busy(pull_busy), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
    fpi_dev_model #(.DEV_ADDR(DA), .RANGE_DEFAULT(RDEF)) i_fpi_dev_model (.scl(scl), .sda(sda),
        .sda_pull(dev_pull), .reg_ptr(ptr), .upper_loads(loads));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask : chk1

    task automatic send(input fpi_op_t op, input logic [6:0] da, input logic [7:0] ra,
                        input logic [31:0] d);
        @(posedge clk_sys);
        cmd <= {op, da, ra, d};
        cmd_valid <= 1'b1;
        do @(posedge clk_sys); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask : send

    task automatic get;
        @(posedge clk_sys);
        rsp_ready <= 1'b1;
        do @(posedge clk_sys); while (rsp_valid !== 1'b1);
        r = rsp;
        rsp_ready <= 1'b0;
    endtask : get

    task automatic wr(input logic [7:0] ra, input logic [15:0] d);
        send(FPI_OP_WRITE, DA, ra, {16'h0000, d});
        get();
        chk1(r.nack, 1'b0);
    endtask : wr

    // Address written first, then read back after a repeated START
    task automatic rd(input logic [7:0] ra, input logic [15:0] exp);
        send(FPI_OP_READ, DA, ra, 32'h0000_0000);
        get();
        chk1(r.nack, 1'b0);
        chk16(r.rdata, exp);
    endtask : rd

    // Hang guard well above the expected run length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            $display("unexpected at %0t: run did not finish", $time);
            give_verdict();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(`FPI_REG_LOWER_WORD, 16'h0000);
        rd(`FPI_REG_UPPER_WORD, 16'h0000);
        rd(`FPI_REG_PULL_RANGE, {12'h000, RDEF});
        chk16({8'h00, ptr}, 16'h0003);
        for (int c = 0; c < 16; c++) begin
            wr(`FPI_REG_PULL_RANGE, {12'ha5c, c[3:0]});
            rd(`FPI_REG_PULL_RANGE, {12'h000, c[3:0]});
        end
        wr(8'hff, 16'h5a5a);
        chk16({8'h00, ptr}, 16'h0000);
        rd(8'hff, 16'h0000);
        send(FPI_OP_WORD, DA, `FPI_REG_LOWER_WORD, 32'hfeab_1234);
        get();
        chk1(r.nack, 1'b0);
        chk1(pull_busy, 1'b1);
        chk16({8'h00, loads}, 16'h0001);
        n = 0;
        while (pull_busy === 1'b1) begin
            @(posedge clk_sys);
            n++;
        end
        chk1(n > WAIT_CYC - 120 && n <= WAIT_CYC, 1'b1);
        rd(`FPI_REG_LOWER_WORD, 16'h1234);
        rd(`FPI_REG_UPPER_WORD, 16'h06ab);
        send(FPI_OP_WORD, DA ^ 7'h01, 8'h00, 32'h0001_0000);
        get();
        chk1(r.nack, 1'b1);
        chk1(pull_busy, 1'b0);
        chk16({8'h00, loads}, 16'h0001);
        send(FPI_OP_READ, DA ^ 7'h40, 8'h00, 32'h0000_0000);
        get();
        chk1(r.nack, 1'b1);
        // Receiver stalls: both answers must wait in the two-entry buffer
        send(FPI_OP_WRITE, DA, `FPI_REG_PULL_RANGE, 32'h0000_0003);
        send(FPI_OP_READ, DA, `FPI_REG_PULL_RANGE, 32'h0000_0000);
        repeat (3500) @(posedge clk_sys);
        chk1(cmd_ready, 1'b0);
        get();
        chk16(r.rdata, 16'h0000);
        get();
        chk16(r.rdata, 16'h0003);
        repeat (3) @(posedge clk_sys);
        chk1(cmd_ready, 1'b1);
        // Idle bus: both lines released, output data pins held at zero
        chk1(scl_oe_n, 1'b1);
        chk1(sda_oe_n, 1'b1);
        chk1(scl_out, 1'b0);
        chk1(sda_out, 1'b0);
        give_verdict();
    end
endmodule : fpi_host_tb
`default_nettype wire
